/* sps_i2c_master.sv */
// i2c bus master model driving the slave's clock and data pins
`timescale 1ns/1ps
module sps_i2c_master (
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task startC;
    sda <= 1'b1;
    #40 scl <= 1'b1;
    #80 sda <= 1'b0;
    #80 scl <= 1'b0;
  endtask
  task stopC;
    sda <= 1'b0;
    #40 scl <= 1'b1;
    #80 sda <= 1'b1;
    #80;
  endtask
  task byteT(input logic [7:0] v, input logic ak);
    logic [8:0] f;
    f = {v, ak};
    for (int i = 8; i >= 0; i--) begin
      sda <= f[i];
      #40 scl <= 1'b1;
      #80 scl <= 1'b0;
      #40;
    end
  endtask
endmodule

/* sps_pkg.sv */
// package: register map, field positions and state for the serial port status block
package sps_pkg;
  localparam logic [7:0]  SPS_ADDR_STATUS    = 8'h94;
  localparam logic [7:0]  SPS_ADDR_CTRL      = 8'h98;
  localparam logic [7:0]  SPS_ADDR_OWNADDR   = 8'h9c;
  localparam logic [7:0]  SPS_ADDR_IRQSTAT   = 8'ha0;
  localparam logic [7:0]  SPS_ADDR_IRQMASK   = 8'ha4;
  localparam int          SPS_BIT_SMP        = 7;
  localparam int          SPS_BIT_CKE        = 6;
  localparam int          SPS_BIT_STOP       = 4;
  localparam int          SPS_BIT_START      = 3;
  localparam int          SPS_BIT_RW         = 2;
  localparam int          SPS_BIT_EN         = 0;
  localparam int          SPS_IRQ_START      = 0;
  localparam int          SPS_IRQ_STOP       = 1;
  localparam int          SPS_IRQ_MATCH      = 2;
  localparam int          SPS_IRQ_NACK       = 3;
  localparam logic [7:0]  SPS_STATUS_RST     = 8'h00;
  localparam logic [6:0]  SPS_OWNADDR_RST    = 7'h00;
  localparam logic [3:0]  SPS_BITCNT_LAST    = 4'h8;
  localparam logic [1:0]  SPS_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  SPS_RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_XFER, ST_SKIP} sps_state_t;

  typedef struct packed {
    logic [1:0] sync0;
    logic [1:0] sync1;
    logic [1:0] prev;
  } sps_pins_t;

  typedef struct packed {
    sps_pins_t   pins;
    sps_state_t  st;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic [7:0]  status;
    logic [1:0]  cfgBits;
    logic        portEn;
    logic [6:0]  ownAddr;
    logic [3:0]  irqStat;
    logic [3:0]  irqMask;
    logic        irq;
    logic        aw;
    logic        w;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } sps_reg_t;
endpackage

/* sps_status_reg.sv */
// serial port status register with i2c condition detection and axi4-lite access
`timescale 1ns/1ps
module sps_status_reg
  import sps_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irqOut
);
  sps_reg_t q;
  sps_reg_t d;
  logic     scl;
  logic     sda;
  logic     sclRise;
  logic     startDet;
  logic     stopDet;
  logic     wrGo;
  logic [3:0] ev;

  assign scl = q.pins.sync1[1];
  assign sda = q.pins.sync1[0];
  assign sclRise = scl && !q.pins.prev[1];
  assign startDet = scl && q.pins.prev[1] && !sda && q.pins.prev[0];
  assign stopDet  = scl && q.pins.prev[1] && sda && !q.pins.prev[0];
  assign wrGo = q.aw && q.w && !q.bValid;

  always_comb begin
    d = q;
    ev = 4'h0;
    d.pins.sync0 = {sclIn, sdaIn};
    d.pins.sync1 = q.pins.sync0;
    d.pins.prev  = q.pins.sync1;
    if (startDet) begin
      d.status[SPS_BIT_START] = 1'b1;
      d.status[SPS_BIT_STOP]  = 1'b0;
      d.st = ST_ADDR;
      d.bitCnt = 4'h0;
      ev[SPS_IRQ_START] = 1'b1;
    end else if (stopDet) begin
      d.status[SPS_BIT_STOP]  = 1'b1;
      d.status[SPS_BIT_START] = 1'b0;
      d.status[SPS_BIT_RW]    = 1'b0;
      d.st = ST_IDLE;
      ev[SPS_IRQ_STOP] = 1'b1;
    end else if (sclRise && q.st != ST_IDLE) begin
      if (q.bitCnt == SPS_BITCNT_LAST) begin
        d.bitCnt = 4'h0;
        case (q.st)
          ST_ADDR: begin
            if (q.shift[7:1] == q.ownAddr) begin
              d.status[SPS_BIT_RW] = q.shift[0];
              d.st = ST_XFER;
              ev[SPS_IRQ_MATCH] = 1'b1;
            end else begin
              d.st = ST_SKIP;
            end
          end
          ST_XFER: begin
            if (q.status[SPS_BIT_RW] && sda) begin
              d.status = SPS_STATUS_RST;
              d.st = ST_IDLE;
              ev[SPS_IRQ_NACK] = 1'b1;
            end
          end
          default: d.st = q.st;
        endcase
      end else begin
        d.shift = {q.shift[6:0], sda};
        d.bitCnt = q.bitCnt + 4'h1;
      end
    end
    if (!q.portEn) begin
      d.status[SPS_BIT_STOP]  = 1'b0;
      d.status[SPS_BIT_START] = 1'b0;
      d.status[SPS_BIT_RW]    = 1'b0;
      d.st = ST_IDLE;
      ev = 4'h0;
    end
    d.status[SPS_BIT_CKE] = q.cfgBits[1];
    d.status[SPS_BIT_SMP] = q.cfgBits[0];
    if (s_axi_awvalid && !q.aw) begin
      d.aw = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w) begin
      d.w = 1'b1;
      d.wData = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                               {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    end
    if (q.bValid && s_axi_bready) begin
      d.bValid = 1'b0;
    end
    if (wrGo) begin
      d.aw = 1'b0;
      d.w = 1'b0;
      d.bValid = 1'b1;
      d.bResp = SPS_RESP_OKAY;
      case (q.awAddr)
        SPS_ADDR_STATUS: d.cfgBits = {q.wData[SPS_BIT_CKE], q.wData[SPS_BIT_SMP]};
        SPS_ADDR_CTRL:    d.portEn = q.wData[SPS_BIT_EN];
        SPS_ADDR_OWNADDR: d.ownAddr = q.wData[6:0];
        SPS_ADDR_IRQSTAT: d.irqStat = q.irqStat & ~q.wData[3:0];
        SPS_ADDR_IRQMASK: d.irqMask = q.wData[3:0];
        default:          d.bResp = SPS_RESP_SLVERR;
      endcase
    end
    d.irqStat = d.irqStat | ev;
    d.irq = |(d.irqStat & d.irqMask);
    d.arReady = 1'b0;
    if (q.rValid && s_axi_rready) begin
      d.rValid = 1'b0;
    end
    if (s_axi_arvalid && !q.arReady && !q.rValid) begin
      d.arReady = 1'b1;
    end
    // rvalid only after the address handshake has completed
    if (s_axi_arvalid && q.arReady) begin
      d.rValid = 1'b1;
      d.rResp = SPS_RESP_OKAY;
      case (s_axi_araddr)
        SPS_ADDR_STATUS:  d.rData = {24'h000000, q.status};
        SPS_ADDR_CTRL:    d.rData = {31'h00000000, q.portEn};
        SPS_ADDR_OWNADDR: d.rData = {25'h0000000, q.ownAddr};
        SPS_ADDR_IRQSTAT: d.rData = {28'h0000000, q.irqStat};
        SPS_ADDR_IRQMASK: d.rData = {28'h0000000, q.irqMask};
        default: begin
          d.rData = 32'h00000000;
          d.rResp = SPS_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.status <= SPS_STATUS_RST;
      q.ownAddr <= SPS_OWNADDR_RST;
      q.pins.sync0 <= 2'h3;
      q.pins.sync1 <= 2'h3;
      q.pins.prev <= 2'h3;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = !q.aw;
  assign s_axi_wready  = !q.w;
  assign s_axi_bvalid  = q.bValid;
  assign s_axi_bresp   = q.bResp;
  assign s_axi_arready = q.arReady;
  assign s_axi_rvalid  = q.rValid;
  assign s_axi_rdata   = q.rData;
  assign s_axi_rresp   = q.rResp;
  assign irqOut        = q.irq;

  a_start_clears_stop: assert property (@(posedge mclk) disable iff (rst)
    startDet && q.portEn |=> !q.status[SPS_BIT_STOP] && q.status[SPS_BIT_START])
    else $error("stop flag not cleared by start");
  a_stop_clears_start: assert property (@(posedge mclk) disable iff (rst)
    stopDet && q.portEn |=> !q.status[SPS_BIT_START] && q.status[SPS_BIT_STOP])
    else $error("start flag not cleared by stop");
  a_disable_clears: assert property (@(posedge mclk) disable iff (rst)
    !q.portEn |=> q.status[SPS_BIT_STOP:SPS_BIT_RW] == 3'h0)
    else $error("flags not cleared while disabled");
  a_rw_idle_zero: assert property (@(posedge mclk) disable iff (rst)
    q.st == ST_IDLE && !startDet |=> !q.status[SPS_BIT_RW])
    else $error("direction flag set outside a transfer");
  a_match_sets_rw: assert property (@(posedge mclk) disable iff (rst)
    q.portEn && !startDet && !stopDet && sclRise && q.st == ST_ADDR
    && q.bitCnt == SPS_BITCNT_LAST && q.shift[7:1] == q.ownAddr
    |=> q.status[SPS_BIT_RW] == $past(q.shift[0]) && q.st == ST_XFER)
    else $error("address match did not load direction");
  a_nack_resets: assert property (@(posedge mclk) disable iff (rst)
    q.portEn && ev[SPS_IRQ_NACK] |=> q.st == ST_IDLE && q.status[5:0] == 6'h00)
    else $error("nack did not reset slave logic");
  a_reset_zero: assert property (@(posedge mclk)
    $fell(rst) |-> q.status == SPS_STATUS_RST)
    else $error("status not zero after reset");
  a_irq_level: assert property (@(posedge mclk) disable iff (rst)
    q.portEn && startDet && q.irqMask[SPS_IRQ_START] |=> irqOut ##1 irqOut)
    else $error("start event did not raise interrupt");
endmodule

/* sps_status_reg_bench.sv */
// self-checking bench for the serial port status register block
`timescale 1ns/1ps
module sps_status_reg_bench import sps_pkg::*; ;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awAddr = 8'h00;
  logic [7:0]  arAddr = 8'h00;
  logic [31:0] wData = 32'h0;
  logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic        awReady, wReady, bValid, arReady, rValid, irqOut, scl, sda;
  logic [1:0]  bResp, rResp;
  logic [31:0] rData;
  int          err_count = 0, checks = 0, cyc = 0;
  sps_i2c_master m (.scl(scl), .sda(sda));
  sps_status_reg dut (.mclk(mclk), .rst(rst), .sclIn(scl), .sdaIn(sda),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .irqOut(irqOut));
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task stop_test;
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task ax(input logic wrt, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
          input logic [1:0] er);
    logic ta, tw, tr, dn;
    logic [31:0] rv;
    logic [1:0] rs;
    @(posedge mclk);
    awAddr <= a;
    arAddr <= a;
    wData <= d;
    awValid <= wrt;
    wValid <= wrt;
    bReady <= wrt;
    arValid <= !wrt;
    rReady <= !wrt;
    do begin
      @(negedge mclk);
      ta = awValid & awReady;
      tw = wValid & wReady;
      tr = arValid & arReady;
      dn = wrt ? bValid : rValid;
      rv = wrt ? 32'h0 : rData;
      rs = wrt ? bResp : rResp;
      @(posedge mclk);
      if (ta) awValid <= 1'b0;
      if (tw) wValid <= 1'b0;
      if (tr) arValid <= 1'b0;
    end while (!dn);
    bReady <= 1'b0;
    rReady <= 1'b0;
    chk(rv, e);
    chk({30'h0, rs}, {30'h0, er});
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ax(1'b1, a, d, 32'h0, SPS_RESP_OKAY);
  endtask
  task st(input logic [7:0] e);
    ax(1'b0, SPS_ADDR_STATUS, 32'h0, {24'h0, e}, SPS_RESP_OKAY);
  endtask
  task irq(input logic e);
    @(negedge mclk);
    chk({31'h0, irqOut}, {31'h0, e});
  endtask
  task tReset;
    st(8'h00);
    wr(SPS_ADDR_STATUS, 32'h1c);
    st(8'h00);
    ax(1'b0, 8'hfc, 32'h0, 32'h0, SPS_RESP_SLVERR);
    ax(1'b1, 8'hfc, 32'h0, 32'h0, SPS_RESP_SLVERR);
  endtask
  task tStart;
    wr(SPS_ADDR_CTRL, 32'h1);
    wr(SPS_ADDR_OWNADDR, 32'h2a);
    wr(SPS_ADDR_IRQMASK, 32'h3);
    m.startC();
    st(8'h08);
    irq(1'b1);
    wr(SPS_ADDR_IRQSTAT, 32'h1);
    irq(1'b0);
  endtask
  task tRead;
    m.byteT(8'h55, 1'b0);
    st(8'h0c);
    irq(1'b0);
    m.byteT(8'hff, 1'b1);
    st(8'h00);
    ax(1'b0, SPS_ADDR_IRQSTAT, 32'h0, 32'hc, SPS_RESP_OKAY);
  endtask
  task tWrite;
    m.startC();
    m.byteT(8'h54, 1'b0);
    st(8'h08);
    wr(SPS_ADDR_IRQSTAT, 32'hf);
    irq(1'b0);
    m.stopC();
    st(8'h10);
    irq(1'b1);
    m.startC();
    st(8'h08);
    m.byteT(8'h57, 1'b0);
    st(8'h08);
    wr(SPS_ADDR_CTRL, 32'h0);
    st(8'h00);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    tReset();
    tStart();
    tRead();
    tWrite();
    stop_test();
  end
endmodule
